// ==== pcbr_host.sv ====
// Host model that drives the register port of the power-control bank.
// Assumes one shared clock and a read answer one cycle after the strobe.
`timescale 1ns/1ps
module pcbr_host (
  input  wire logic        core_clk,
  output logic             wr_en,
  output logic             rd_en,
  output logic [5:0]       addr,
  output logic [23:0]      wr_data,
  input  wire logic [23:0] rd_data,
  input  wire logic        rd_valid
);
  // ----------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------
  // The port idles from time zero so reset never sees a stray access.
  initial begin
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    addr    = 6'h00;
    wr_data = 24'h000000;
  end

  // One write with a single-cycle strobe.
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(posedge core_clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge core_clk);
    wr_en   <= 1'b0;
  endtask

  // One read; a missing answer returns unknown data so the compare fails.
  task automatic rd(input logic [5:0] a, output logic [23:0] d);
    d = 24'hxxxxxx;
    @(posedge core_clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge core_clk);
    rd_en <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      #1;
      if (rd_valid === 1'b1) begin
        d = rd_data;
        break;
      end
      @(posedge core_clk);
    end
  endtask
endmodule

// ==== pcbr_pkg.sv ====
// Constants and field layouts for the power-control and backup register bank.
// Assumes a 24-bit register word and a 6-bit register address.
package pcbr_pkg;

  // --------------------------------------------------------------
  // Register addresses
  // --------------------------------------------------------------
  localparam logic [5:0] ADDR_CUT    = 6'h0e;
  localparam logic [5:0] ADDR_PC2    = 6'h0f;
  localparam logic [5:0] ADDR_SPAREA = 6'h10;
  localparam logic [5:0] ADDR_SPAREB = 6'h11;
  localparam logic [5:0] ADDR_SCRA   = 6'h12;
  localparam logic [5:0] ADDR_SCRB   = 6'h13;

  // --------------------------------------------------------------
  // Field positions and masks
  // --------------------------------------------------------------
  localparam int          POS_WDI       = 12;
  localparam logic [23:0] CUT_MASK      = 24'h00ffff;
  localparam logic [23:0] PC2_MASK      = 24'hc67fff;
  localparam logic [23:0] PC2_SYS_MASK  = 24'hc01000;
  localparam logic [23:0] RST_CUT       = 24'h000000;
  localparam logic [23:0] RST_PC2       = 24'h400000;
  localparam logic [23:0] RST_SCR       = 24'h000000;
  localparam int          SYNC_STAGES   = 2;
  localparam int          N_PINS        = 7;

  // Power control two, bit 23 down to bit 0.
  typedef struct packed {
    logic [1:0] sleep_delay_sel;
    logic [2:0] rsvd_hi;
    logic [1:0] clk_drive;
    logic [1:0] rsvd_mid;
    logic [1:0] bus_drive;
    logic       watchdog_in_reset_en;
    logic       secondary_sleep_polarity;
    logic       sleep_req_polarity;
    logic [1:0] button3_filter_sel;
    logic [1:0] button2_filter_sel;
    logic [1:0] button1_filter_sel;
    logic       button3_reset_en;
    logic       button2_reset_en;
    logic       button1_reset_en;
    logic       auto_reboot_en;
  } pcbr_pc2_t;

  // Power cut control, low 16 bits.
  typedef struct packed {
    logic [3:0] cut_limit;
    logic [3:0] cut_tally;
    logic [7:0] cut_timer;
  } pcbr_cut_t;

endpackage

// ==== pcbr_regs.sv ====
// Power-control configuration and battery-backed scratch register bank.
// Assumes a simple same-clock register port and raw, asynchronous pins.
// Assumes reset comes from the clock domain's own power-on reset, and that
// system_reset_n comes from the device pin, low while a system reset lasts.
//
// How it works
// - The cut register holds an 8-bit timer, 4-bit tally and 4-bit limit cleared on reset.
// - The auto reboot bit asks for a restart after system reset only when set.
// - Bits 1 to 3 let each button input raise a system reset request.
// - Each button has a 2-bit filter select at bits 4-5, 6-7 and 8-9, cleared on reset.
// - Bit 10 makes the primary sleep request input active low.
// - Bit 11 makes the secondary sleep request input active low.
// - Bit 12 lets the watchdog input reset the system and is cleared by system reset.
`timescale 1ns/1ps
module pcbr_regs (
  // Clock, power-on reset and the system reset pin.
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        system_reset_n,
  // Register port.
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [5:0]  addr,
  input  wire logic [23:0] wr_data,
  output logic      [23:0] rd_data,
  output logic             rd_valid,
  // Raw pins.
  input  wire logic        button1_in,
  input  wire logic        button2_in,
  input  wire logic        button3_in,
  input  wire logic        watchdog_in,
  input  wire logic        sleep_req_in,
  input  wire logic        secondary_sleep_req,
  // Register contents and decoded requests.
  output pcbr_pkg::pcbr_pc2_t ctrl,
  output pcbr_pkg::pcbr_cut_t cut,
  output logic             sys_reset_req,
  output logic             sleep_active,
  output logic             secondary_sleep_active
);

  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  logic [pcbr_pkg::N_PINS-1:0] pin_raw;
  logic [pcbr_pkg::N_PINS-1:0] meta_r;
  logic [pcbr_pkg::N_PINS-1:0] pin_r;
  logic                        sys_rst;

  assign pin_raw = {system_reset_n, secondary_sleep_req, sleep_req_in,
                    watchdog_in, button3_in, button2_in, button1_in};
  assign sys_rst = ~pin_r[6];

  // Two stages per pin; the first stage is read only by the second.
  // The preset of one reads as no system reset and no watchdog request, but as
  // active sleep inputs, since the polarity bits clear on reset; the button
  // enables clear on reset as well, so a preset button level cannot raise a request.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_r <= 7'h7f;
      pin_r  <= 7'h7f;
    end else begin
      meta_r <= pin_raw;
      pin_r  <= meta_r;
    end
  end

  // --------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------
  logic [23:0] cut_r;
  logic [23:0] pc2_r;
  logic [23:0] scra_r;
  logic [23:0] scrb_r;
  logic [23:0] pc2_nxt;
  logic        wr_cut;
  logic        wr_pc2;
  logic        wr_scra;
  logic        wr_scrb;

  // Address decode for writes.
  // Spare and unmapped addresses decode to nothing, which is what makes a
  // write there harmless.
  assign wr_cut  = wr_en && (addr == pcbr_pkg::ADDR_CUT);
  assign wr_pc2  = wr_en && (addr == pcbr_pkg::ADDR_PC2);
  assign wr_scra = wr_en && (addr == pcbr_pkg::ADDR_SCRA);
  assign wr_scrb = wr_en && (addr == pcbr_pkg::ADDR_SCRB);

  // System reset restores only its own fields; a write in that cycle loses.
  // The loss is deliberate: a host write racing a system reset cannot be
  // trusted, and the host sets its fields again once it has restarted.
  // reboot bit kept
  assign pc2_nxt = sys_rst
    ? ((pc2_r & ~pcbr_pkg::PC2_SYS_MASK) | (pcbr_pkg::RST_PC2 & pcbr_pkg::PC2_SYS_MASK))
    : (wr_pc2 ? (wr_data & pcbr_pkg::PC2_MASK) : pc2_r);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cut_r  <= pcbr_pkg::RST_CUT;
      pc2_r  <= pcbr_pkg::RST_PC2;
      scra_r <= pcbr_pkg::RST_SCR;
      scrb_r <= pcbr_pkg::RST_SCR;
    end else begin
      pc2_r <= pc2_nxt;
      if (wr_cut) begin
        cut_r <= wr_data & pcbr_pkg::CUT_MASK;
      end
      if (wr_scra) begin
        scra_r <= wr_data;
      end
      if (wr_scrb) begin
        scrb_r <= wr_data;
      end
    end
  end

  // --------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------
  logic [23:0] rd_sel;

  // Spare words and unmapped addresses read zero.
  // unused read zero
  assign rd_sel = (addr == pcbr_pkg::ADDR_CUT)  ? cut_r  :
                  (addr == pcbr_pkg::ADDR_PC2)  ? pc2_r  :
                  (addr == pcbr_pkg::ADDR_SCRA) ? scra_r :
                  (addr == pcbr_pkg::ADDR_SCRB) ? scrb_r : 24'h000000;

  // Read data is held until the next read.
  // Holding it lets a slow host pick it up late; the price is a 24-bit
  // register in place of a purely combinational read path.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rd_data  <= 24'h000000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= rd_sel;
      end
    end
  end

  // --------------------------------------------------------------
  // Control outputs
  // --------------------------------------------------------------
  logic        btn_rst;
  logic        wdi_rst;
  logic        sleep_nxt;
  logic        sleep2_nxt;

  // The control word and the cut fields leave the bank straight from flops,
  // so the logic that acts on them always sees settled values.
  assign ctrl = pc2_r;
  assign cut  = cut_r[15:0];

  assign btn_rst = (ctrl.button1_reset_en & pin_r[0]) |
                   (ctrl.button2_reset_en & pin_r[1]) |
                   (ctrl.button3_reset_en & pin_r[2]);
  assign wdi_rst = ctrl.watchdog_in_reset_en & ~pin_r[3];
  assign sleep_nxt  = pin_r[4] ^ ctrl.sleep_req_polarity;
  assign sleep2_nxt = pin_r[5] ^ ctrl.secondary_sleep_polarity;

  // Registered so the outputs never glitch on a pin edge.
  // The cost is one more cycle of latency, three edges from pin to output
  // in all, which is far below any button or watchdog timescale.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sys_reset_req          <= 1'b0;
      sleep_active           <= 1'b0;
      secondary_sleep_active <= 1'b0;
    end else begin
      sys_reset_req          <= btn_rst | wdi_rst;
      sleep_active           <= sleep_nxt;
      secondary_sleep_active <= sleep2_nxt;
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  // Storage checks run one cycle after the write, against the masked bus
  // data, so a wrong mask is caught in the cycle in which it bites.
  a_cut_write: assert property (@(posedge core_clk) disable iff (reset)
    wr_cut |=> cut_r == ($past(wr_data) & 24'h00ffff))
    else $error("cut register write mismatch");
  a_pc2_word: assert property (@(posedge core_clk) disable iff (reset)
    wr_pc2 && !sys_rst |=> pc2_r == ($past(wr_data) & pcbr_pkg::PC2_MASK))
    else $error("power control word stored with reserved bits");

  // A read of the cut register shows the stored fields and a zero top byte.
  a_cut_read: assert property (@(posedge core_clk) disable iff (reset)
    rd_en && addr == pcbr_pkg::ADDR_CUT |=> rd_valid && rd_data == {8'h00, $past(cut)})
    else $error("cut register read mismatch");

  // The reboot enable takes the written bit and must survive a system reset;
  // losing it there would defeat the very restart that it asks for.
  a_reboot_bit: assert property (@(posedge core_clk) disable iff (reset)
    wr_pc2 && !sys_rst |=> ctrl.auto_reboot_en == $past(wr_data[0]))
    else $error("auto reboot bit not stored");
  a_reboot_keep: assert property (@(posedge core_clk) disable iff (reset)
    sys_rst |=> $stable(ctrl.auto_reboot_en))
    else $error("auto reboot bit lost in system reset");

  // Button gating. Each enable is checked against its own pin, and with all
  // enables clear no pin level may raise a request.
  a_btn1_reset: assert property (@(posedge core_clk) disable iff (reset)
    (ctrl.button1_reset_en && pin_r[0]) |=> sys_reset_req)
    else $error("button one reset request missing");
  a_btn_reset: assert property (@(posedge core_clk) disable iff (reset)
    (ctrl.button2_reset_en && pin_r[1]) |=> sys_reset_req)
    else $error("button reset request missing");
  a_btn3_reset: assert property (@(posedge core_clk) disable iff (reset)
    (ctrl.button3_reset_en && pin_r[2]) |=> sys_reset_req)
    else $error("button three reset request missing");
  a_btn_block: assert property (@(posedge core_clk) disable iff (reset)
    (!btn_rst && !wdi_rst) |=> !sys_reset_req)
    else $error("reset request without cause");
  a_btn_none: assert property (@(posedge core_clk) disable iff (reset)
    !ctrl.button1_reset_en && !ctrl.button2_reset_en && !ctrl.button3_reset_en && !wdi_rst
    |=> !sys_reset_req)
    else $error("disabled button raised a reset request");

  // The filter selects take the written value and keep it through a system
  // reset; the debounce timing that they choose lives outside this bank.
  a_filter_sel: assert property (@(posedge core_clk) disable iff (reset)
    wr_pc2 && !sys_rst |=> ctrl.button3_filter_sel == $past(wr_data[9:8]))
    else $error("filter select not stored");
  a_filter_lo: assert property (@(posedge core_clk) disable iff (reset)
    wr_pc2 && !sys_rst |=> {ctrl.button2_filter_sel, ctrl.button1_filter_sel} == $past(wr_data[7:4]))
    else $error("low filter selects not stored");
  a_sel_keep: assert property (@(posedge core_clk) disable iff (reset)
    sys_rst |=> $stable(pc2_r[9:4]))
    else $error("filter selects lost in system reset");

  // Sleep polarity. The checks start only once reset is sampled low, because
  // the output register is still held in the cycle that releases reset.
  a_sleep_pol: assert property (@(posedge core_clk) disable iff (reset)
    !reset |=> sleep_active == ($past(pin_r[4]) ^ $past(pc2_r[10])))
    else $error("primary sleep polarity wrong");
  a_sleep2_pol: assert property (@(posedge core_clk) disable iff (reset)
    !reset |=> secondary_sleep_active == ($past(pin_r[5]) ^ $past(pc2_r[11])))
    else $error("secondary sleep polarity wrong");
  a_pol_keep: assert property (@(posedge core_clk) disable iff (reset)
    sys_rst |=> $stable(pc2_r[11:10]))
    else $error("sleep polarity lost in system reset");

  // Watchdog path: an enabled low input requests reset, a high one does not,
  // and a system reset clears the enable and reloads the delay while the
  // reboot and button enables in bits 0 to 3 stay as they were.
  a_wdi_reset: assert property (@(posedge core_clk) disable iff (reset)
    (ctrl.watchdog_in_reset_en && !pin_r[3]) |=> sys_reset_req)
    else $error("watchdog reset request missing");
  a_wdi_high: assert property (@(posedge core_clk) disable iff (reset)
    (ctrl.watchdog_in_reset_en && pin_r[3] && !btn_rst) |=> !sys_reset_req)
    else $error("idle watchdog raised a reset request");
  a_wdi_clear: assert property (@(posedge core_clk) disable iff (reset)
    sys_rst |=> !ctrl.watchdog_in_reset_en && ctrl.sleep_delay_sel == 2'h1)
    else $error("system reset did not clear fields");
  a_wdi_keep: assert property (@(posedge core_clk) disable iff (reset)
    sys_rst && !$past(sys_rst) |=> $stable(pc2_r[3:0]))
    else $error("system reset touched backed fields");

  // Unused space reads zero and ignores writes.
  a_unused_zero: assert property (@(posedge core_clk) disable iff (reset)
    rd_en && (addr == pcbr_pkg::ADDR_SPAREA || addr == pcbr_pkg::ADDR_SPAREB)
    |=> rd_valid && rd_data == 24'h000000)
    else $error("spare word read nonzero");
  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (reset)
    rd_en && (addr < pcbr_pkg::ADDR_CUT || addr > pcbr_pkg::ADDR_SCRB)
    |=> rd_valid && rd_data == 24'h000000)
    else $error("unmapped address read nonzero");
  a_spare_nowrite: assert property (@(posedge core_clk) disable iff (reset)
    wr_en && (addr == pcbr_pkg::ADDR_SPAREA || addr == pcbr_pkg::ADDR_SPAREB) && !sys_rst
    |=> $stable(cut_r) && $stable(pc2_r) && $stable(scra_r) && $stable(scrb_r))
    else $error("spare word write changed a register");
  a_rsvd_zero: assert property (@(posedge core_clk) disable iff (reset)
    ##1 (pc2_r[16:15] == 2'h0) && (pc2_r[21:19] == 3'h0) && (cut_r[23:16] == 8'h00))
    else $error("reserved bits nonzero");

  // --------------------------------------------------------------
  // Coverage of the main scenarios
  // --------------------------------------------------------------
  // Each cover but c_scratch_rw shows that the bench reaches a path the assertions guard.
  c_scratch_rw: cover property (@(posedge core_clk) disable iff (reset)
    wr_scra ##[1:4] (rd_en && addr == pcbr_pkg::ADDR_SCRA));
  c_wdi_reset: cover property (@(posedge core_clk) disable iff (reset)
    wdi_rst ##1 sys_reset_req);
  c_sys_clear: cover property (@(posedge core_clk) disable iff (reset)
    ctrl.watchdog_in_reset_en ##1 sys_rst);
  c_btn_reset: cover property (@(posedge core_clk) disable iff (reset)
    btn_rst ##1 sys_reset_req);
  c_sleep_low: cover property (@(posedge core_clk) disable iff (reset)
    (ctrl.sleep_req_polarity && !pin_r[4]) ##1 sleep_active);

endmodule

// ==== power_control_backup_regs_test.sv ====
// Self-checking bench for the power-control and backup register bank.
// Assumes the host model drives the register port and the bench the pins.
`timescale 1ns/1ps
module power_control_backup_regs_test;
  logic        core_clk, reset, system_reset_n, wr_en, rd_en, rd_valid, wdog;
  logic        rst_req, slp_act, sec_act;
  logic [5:0]  addr;
  logic [23:0] wr_data, rd_data, got;
  logic [2:0]  btn;
  logic [1:0]  slp;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  pcbr_pkg::pcbr_pc2_t ctrl;
  pcbr_pkg::pcbr_cut_t cut;
  localparam logic [5:0]  ADR [7] = '{6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12, 6'h13, 6'h3f};
  localparam logic [23:0] RV [7] = '{24'h0, 24'h400000, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0};
  localparam logic [23:0] WV [7] = '{24'h00ffff, 24'hc67fff, 24'h0, 24'h0, 24'hffffff,
                                     24'hffffff, 24'h0};

  pcbr_regs DUT (.core_clk(core_clk), .reset(reset), .system_reset_n(system_reset_n),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid), .button1_in(btn[0]), .button2_in(btn[1]), .button3_in(btn[2]),
    .watchdog_in(wdog), .sleep_req_in(slp[0]), .secondary_sleep_req(slp[1]),
    .ctrl(ctrl), .cut(cut), .sys_reset_req(rst_req), .sleep_active(slp_act),
    .secondary_sleep_active(sec_act));
  pcbr_host u_host (.core_clk(core_clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  // Compare and count; a mismatch is reported at once.
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Pins pass two sync stages and an output register, so four edges is ample.
  task automatic settle;
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // A hang is cut short here and counted as a mismatch.
  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    reset          = 1'b1;
    system_reset_n = 1'b1;
    btn            = 3'h0;
    wdog           = 1'b1;
    slp            = 2'h3;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    // Reset values, then all-ones writes show which bits really store.
    foreach (ADR[i]) begin
      u_host.rd(ADR[i], got);
      chk(got, RV[i]);
      u_host.wr(ADR[i], 24'hffffff);
      u_host.rd(ADR[i], got);
      chk(got, WV[i]);
    end
    chk({8'h0, cut}, 24'h00ffff);
    chk({20'h0, ctrl.button3_filter_sel, 2'h0}, 24'h00000c);
    chk({23'h0, ctrl.auto_reboot_en}, 24'h1);
    @(posedge core_clk);
    slp  <= 2'h0;
    wdog <= 1'b0;
    settle;
    chk({22'h0, sec_act, slp_act}, 24'h3);
    chk({23'h0, rst_req}, 24'h1);
    // System reset clears only the watchdog enable and reloads the delay.
    @(posedge core_clk);
    system_reset_n <= 1'b0;
    settle;
    @(posedge core_clk);
    system_reset_n <= 1'b1;
    settle;
    chk({23'h0, rst_req}, 24'h0);
    u_host.rd(6'h0f, got);
    chk(got, 24'h466fff);
    u_host.rd(6'h12, got);
    chk(got, 24'hffffff);
    // Each button resets only while its own enable is set.
    for (int i = 0; i < 3; i++) begin
      u_host.wr(6'h0f, 24'h000002 << i);
      @(posedge core_clk);
      btn <= 3'h1 << i;
      settle;
      chk({23'h0, rst_req}, 24'h1);
      u_host.wr(6'h0f, 24'h000000);
      settle;
      chk({23'h0, rst_req}, 24'h0);
      @(posedge core_clk);
      btn <= 3'h0;
    end
    chk({22'h0, sec_act, slp_act}, 24'h0);
    tally_and_finish;
  end
endmodule
